/* uptt_pkg.sv */
package uptt_pkg;
	localparam int NPORT = 3;

	// Register byte addresses
	localparam logic [31:0] PAD_CTL0_OFS [NPORT] = '{32'h0352_0088, 32'h0352_00C8, 32'h0352_0108};
	localparam logic [31:0] PAD_CTL1_OFS [NPORT] = '{32'h0352_008C, 32'h0352_00CC, 32'h0352_010C};
	localparam logic [31:0] PAD_CTL3_OFS [NPORT] = '{32'h0352_0094, 32'h0352_00D4, 32'h0352_0114};
	localparam logic [31:0] PORT_SC_OFS  [NPORT] = '{32'h0361_0460, 32'h0361_0470, 32'h0361_0480};
	localparam logic [31:0] PORT_TC_OFS  [NPORT] = '{32'h0361_0464, 32'h0361_0474, 32'h0361_0484};
	localparam logic [31:0] BIAS_OFS     = 32'h0352_0284;
	localparam logic [31:0] CMD_OFS      = 32'h0361_0020;
	localparam logic [31:0] STS_OFS      = 32'h0361_0024;
	localparam logic [31:0] FUSE_PRI_OFS = 32'h0381_01F0;
	localparam logic [31:0] FUSE_EXT_OFS = 32'h0381_0350;

	// Field positions
	localparam int TEST_MSB    = 31;
	localparam int TEST_LSB    = 28;
	localparam int PWR_BIT     = 9;
	localparam int CONNECT_BIT = 0;
	localparam int RUN_BIT     = 0;
	localparam int HALT_BIT    = 0;
	localparam int PAD_DN_BIT  = 26;
	localparam int EDGE_MSB    = 8;
	localparam int EDGE_LSB    = 6;
	localparam int DRV_MSB     = 5;
	localparam int DRV_LSB     = 0;
	localparam int PULL_MSB    = 30;
	localparam int PULL_LSB    = 26;
	localparam int TERM_MSB    = 6;
	localparam int TERM_LSB    = 3;
	localparam int SQ_MSB      = 2;
	localparam int SQ_LSB      = 0;
	localparam int TXEQ_MSB    = 2;
	localparam int TXEQ_LSB    = 1;
	localparam int RXEQ_MSB    = 7;
	localparam int RXEQ_LSB    = 6;
	localparam int EDGE_W      = EDGE_MSB - EDGE_LSB + 1;
	localparam int DRV_W       = DRV_MSB - DRV_LSB + 1;
	localparam int PULL_W      = PULL_MSB - PULL_LSB + 1;
	localparam int TERM_W      = TERM_MSB - TERM_LSB + 1;
	localparam int SQ_W        = SQ_MSB - SQ_LSB + 1;
	localparam int EQ_W        = TXEQ_MSB - TXEQ_LSB + 1;
	localparam int TEST_W      = TEST_MSB - TEST_LSB + 1;

	// Fuse fields returned on read
	localparam logic [31:0] FUSE_PRI_MASK = 32'h007F_FFBF;
	localparam logic [31:0] FUSE_EXT_MASK = 32'h0000_1FFF;

	// Reset values
	localparam logic [31:0] PAD_CTL0_RST = 32'h0400_0000;
	localparam logic [31:0] ZERO_RST     = 32'h0000_0000;

	// Halt timing
	localparam int CORE_CLK_MHZ = 125;
	localparam int HALT_TIME_NS = 128;
	localparam int HALT_CYCLES  = (HALT_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam logic [4:0] HALT_CNT_LAST = 5'(HALT_CYCLES - 1);

	typedef enum logic [3:0] {
		TEST_NORMAL   = 4'h0,
		TEST_J        = 4'h1,
		TEST_K        = 4'h2,
		TEST_SE0_NAK  = 4'h3,
		TEST_PACKET   = 4'h4,
		TEST_FORCE_EN = 4'h5
	} uptt_test_e;

	typedef enum logic [1:0] {
		ST_RUNNING  = 2'b00,
		ST_STOPPING = 2'b01,
		ST_HALTED   = 2'b10
	} uptt_halt_e;

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction
endpackage

/* uptt_halt_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module uptt_halt_seq
	import uptt_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_resetn,
	input  wire logic i_run_stop,
	output var  logic o_halted
);
	import uptt_pkg::*;

	uptt_halt_e state;
	uptt_halt_e next_state;
	logic [4:0] cnt;

	always_comb begin
		next_state = state;
		case (state)
			ST_RUNNING: begin
				if (!i_run_stop) next_state = ST_STOPPING;
			end
			ST_STOPPING: begin
				if (i_run_stop) next_state = ST_RUNNING;
				else if (cnt == HALT_CNT_LAST) next_state = ST_HALTED;
			end
			ST_HALTED: begin
				if (i_run_stop) next_state = ST_RUNNING;
			end
			default: next_state = ST_HALTED;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state    <= ST_HALTED;
			cnt      <= '0;
			o_halted <= 1'b1;
		end else begin
			state    <= next_state;
			cnt      <= (state == ST_STOPPING) ? cnt + 5'h01 : 5'h00;
			o_halted <= (next_state == ST_HALTED);
		end
	end
endmodule
`default_nettype wire

/* uptt_line_test.sv */
`timescale 1ns/1ps
`default_nettype none
module uptt_line_test
	import uptt_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire logic              i_resetn,
	input  wire logic [TEST_W-1:0] i_test_ctl,
	output var  logic              o_test_j,
	output var  logic              o_test_k,
	output var  logic              o_test_se0_nak,
	output var  logic              o_test_packet,
	output var  logic              o_force_enable
);
	import uptt_pkg::*;

	// Unlisted codes leave the line in normal operation
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_test_j       <= 1'b0;
			o_test_k       <= 1'b0;
			o_test_se0_nak <= 1'b0;
			o_test_packet  <= 1'b0;
			o_force_enable <= 1'b0;
		end else begin
			o_test_j       <= (i_test_ctl == TEST_J);
			o_test_k       <= (i_test_ctl == TEST_K);
			o_test_se0_nak <= (i_test_ctl == TEST_SE0_NAK);
			o_test_packet  <= (i_test_ctl == TEST_PACKET);
			o_force_enable <= (i_test_ctl == TEST_FORCE_EN);
		end
	end
endmodule
`default_nettype wire

/* uptt_top.sv */
// Functional notes
// - Test field selects J, K, SE0_NAK, packet, force
// - Controller reports halted; software polls it
// - Pad power-down bit holds pad down
// - Edge rate: code 000 slowest, 111 fastest
// - Drive strength: zero highest, ones lowest current
// - Pull-down and termination adjust in word 1
// - Squelch level directly writable in bias word
// - Transmit equalisation selects AC gain
// - Receive equalisation sets o_rxeq from word 3; squelch level is in bias word
// - Primary fuse returns drive strengths, port0 termination
// - Extended fuse returns terminations and pull-down
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module uptt_top
	import uptt_pkg::*;
(
	input  wire logic                      i_core_clk,
	input  wire logic                      i_resetn,
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [31:0]               i_paddr,
	input  wire logic [31:0]               i_pwdata,
	input  wire logic [3:0]                i_pstrb,
	output var  logic [31:0]               o_prdata,
	output var  logic                      o_pready,
	output var  logic                      o_pslverr,
	input  wire logic [31:0]               i_primary_fuse,
	input  wire logic [31:0]               i_extended_fuse,
	input  wire logic [NPORT-1:0]          i_port_attached,
	output logic                           o_run_stop,
	output logic                           o_controller_halted,
	output logic [NPORT-1:0]               o_port_power,
	output logic [NPORT-1:0]               o_test_j,
	output logic [NPORT-1:0]               o_test_k,
	output logic [NPORT-1:0]               o_test_se0_nak,
	output logic [NPORT-1:0]               o_test_packet,
	output logic [NPORT-1:0]               o_force_enable,
	output logic [NPORT-1:0]               o_pad_power_down,
	output logic [NPORT*EDGE_W-1:0]        o_edge_rate,
	output logic [NPORT*DRV_W-1:0]         o_drive_strength,
	output logic [NPORT*PULL_W-1:0]        o_pulldown,
	output logic [NPORT*TERM_W-1:0]        o_termination,
	output logic [NPORT*EQ_W-1:0]          o_txeq,
	output logic [NPORT*EQ_W-1:0]          o_rxeq,
	output logic [SQ_W-1:0]                o_squelch
);
	import uptt_pkg::*;

	logic [31:0]       pad_ctl0 [NPORT];
	logic [31:0]       pad_ctl1 [NPORT];
	logic [31:0]       pad_ctl3 [NPORT];
	logic [TEST_W-1:0] test_ctl [NPORT];
	logic [NPORT-1:0]  port_power;
	logic [31:0]       bias;
	logic              run_stop;
	logic              halted;

	logic [NPORT-1:0]  hit_c0;
	logic [NPORT-1:0]  hit_c1;
	logic [NPORT-1:0]  hit_c3;
	logic [NPORT-1:0]  hit_sc;
	logic [NPORT-1:0]  hit_tc;
	logic              hit_bias;
	logic              hit_cmd;
	logic              hit_sts;
	logic              hit_fp;
	logic              hit_fe;
	logic              mapped;
	logic              setup;
	logic              wr_en;
	logic [31:0]       rd_word;

	// Bus decode
	assign hit_bias = (i_paddr == BIAS_OFS);
	assign hit_cmd  = (i_paddr == CMD_OFS);
	assign hit_sts  = (i_paddr == STS_OFS);
	assign hit_fp   = (i_paddr == FUSE_PRI_OFS);
	assign hit_fe   = (i_paddr == FUSE_EXT_OFS);
	assign mapped   = |{hit_c0, hit_c1, hit_c3, hit_sc, hit_tc, hit_bias, hit_cmd, hit_sts,
		hit_fp, hit_fe};
	assign setup    = i_psel & ~i_penable;
	assign wr_en    = i_psel & i_penable & o_pready & i_pwrite;

	// Zero-wait slave: ready for exactly the access cycle
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= ZERO_RST;
		end else begin
			o_pready  <= setup;
			o_pslverr <= setup & ~mapped;
			o_prdata  <= (setup & ~i_pwrite) ? rd_word : ZERO_RST;
		end
	end

	always_comb begin
		rd_word = ZERO_RST;
		for (int p = 0; p < NPORT; p++) begin
			if (hit_c0[p]) rd_word = pad_ctl0[p];
			if (hit_c1[p]) rd_word = pad_ctl1[p];
			if (hit_c3[p]) rd_word = pad_ctl3[p];
			if (hit_sc[p]) begin
				rd_word[PWR_BIT]     = port_power[p];
				rd_word[CONNECT_BIT] = i_port_attached[p];
			end
			if (hit_tc[p]) rd_word[TEST_MSB:TEST_LSB] = test_ctl[p];
		end
		if (hit_bias) rd_word = bias;
		if (hit_cmd) rd_word[RUN_BIT] = run_stop;
		if (hit_sts) rd_word[HALT_BIT] = halted;
		if (hit_fp) rd_word = i_primary_fuse & FUSE_PRI_MASK;
		if (hit_fe) rd_word = i_extended_fuse & FUSE_EXT_MASK;
	end

	// Shared registers
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bias     <= ZERO_RST;
			run_stop <= 1'b0;
		end else if (wr_en) begin
			if (hit_bias) bias <= apply_strb(bias, i_pwdata, i_pstrb);
			if (hit_cmd && i_pstrb[0]) run_stop <= i_pwdata[RUN_BIT];
		end
	end

	assign o_run_stop          = run_stop;
	assign o_controller_halted = halted;
	assign o_squelch           = bias[SQ_MSB:SQ_LSB];

	uptt_halt_seq u_halt (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_run_stop (run_stop),
		.o_halted   (halted)
	);

	for (genvar p = 0; p < NPORT; p++) begin : g_port
		assign hit_c0[p] = (i_paddr == PAD_CTL0_OFS[p]);
		assign hit_c1[p] = (i_paddr == PAD_CTL1_OFS[p]);
		assign hit_c3[p] = (i_paddr == PAD_CTL3_OFS[p]);
		assign hit_sc[p] = (i_paddr == PORT_SC_OFS[p]);
		assign hit_tc[p] = (i_paddr == PORT_TC_OFS[p]);

		always_ff @(posedge i_core_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				pad_ctl0[p]   <= PAD_CTL0_RST;
				pad_ctl1[p]   <= ZERO_RST;
				pad_ctl3[p]   <= ZERO_RST;
				test_ctl[p]   <= TEST_NORMAL;
				port_power[p] <= 1'b0;
			end else if (wr_en) begin
				if (hit_c0[p]) pad_ctl0[p] <= apply_strb(pad_ctl0[p], i_pwdata, i_pstrb);
				if (hit_c1[p]) pad_ctl1[p] <= apply_strb(pad_ctl1[p], i_pwdata, i_pstrb);
				if (hit_c3[p]) pad_ctl3[p] <= apply_strb(pad_ctl3[p], i_pwdata, i_pstrb);
				if (hit_sc[p] && i_pstrb[1]) port_power[p] <= i_pwdata[PWR_BIT];
				if (hit_tc[p] && i_pstrb[3]) test_ctl[p] <= i_pwdata[TEST_MSB:TEST_LSB];
			end
		end

		assign o_port_power[p]                = port_power[p];
		assign o_pad_power_down[p]            = pad_ctl0[p][PAD_DN_BIT];
		assign o_edge_rate[p*EDGE_W +: EDGE_W] = pad_ctl0[p][EDGE_MSB:EDGE_LSB];
		assign o_drive_strength[p*DRV_W +: DRV_W] = pad_ctl0[p][DRV_MSB:DRV_LSB];
		assign o_pulldown[p*PULL_W +: PULL_W] = pad_ctl1[p][PULL_MSB:PULL_LSB];
		assign o_termination[p*TERM_W +: TERM_W] = pad_ctl1[p][TERM_MSB:TERM_LSB];
		assign o_txeq[p*EQ_W +: EQ_W]         = pad_ctl3[p][TXEQ_MSB:TXEQ_LSB];
		assign o_rxeq[p*EQ_W +: EQ_W]         = pad_ctl3[p][RXEQ_MSB:RXEQ_LSB];

		uptt_line_test u_line (
			.i_core_clk     (i_core_clk),
			.i_resetn       (i_resetn),
			.i_test_ctl     (test_ctl[p]),
			.o_test_j       (o_test_j[p]),
			.o_test_k       (o_test_k[p]),
			.o_test_se0_nak (o_test_se0_nak[p]),
			.o_test_packet  (o_test_packet[p]),
			.o_force_enable (o_force_enable[p])
		);

		test_j_select_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
			test_ctl[p] == TEST_J |=> o_test_j[p] && !o_test_k[p] && !o_test_packet[p])
			else $error("test J not selected");

		pad_release_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
			wr_en && hit_c0[p] && i_pstrb[3] && !i_pwdata[PAD_DN_BIT]
			|=> !o_pad_power_down[p] [*2])
			else $error("pad power-down not released");
	end

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	halt_timing_a: assert property ($fell(o_run_stop) |->
		!o_controller_halted [*8] ##[1:12] o_controller_halted)
		else $error("halted flag timing wrong");

	run_clears_a: assert property ($rose(o_run_stop) |=> !o_controller_halted)
		else $error("halted flag not cleared on run");

	apb_ready_a: assert property (setup |=> o_pready ##1 !o_pready)
		else $error("ready not one access cycle");

	unmapped_err_a: assert property (setup && !mapped |=> o_pslverr && o_pready)
		else $error("unmapped access not flagged");

	pri_fuse_read_a: assert property (setup && hit_fp && !i_pwrite |=>
		o_prdata[DRV_MSB:DRV_LSB] == $past(i_primary_fuse[DRV_MSB:DRV_LSB])
		&& o_prdata[31:23] == '0)
		else $error("primary fuse read wrong");

	ext_fuse_read_a: assert property (setup && hit_fe && !i_pwrite |=>
		o_prdata[12:0] == $past(i_extended_fuse[12:0]) && o_prdata[31:13] == '0)
		else $error("extended fuse read wrong");

	squelch_write_a: assert property (wr_en && hit_bias && i_pstrb[0] |=>
		o_squelch == $past(i_pwdata[SQ_MSB:SQ_LSB]))
		else $error("squelch write lost");

	edge_rate_a: assert property (wr_en && hit_c0[0] && i_pstrb[1:0] == 2'h3 |=>
		o_edge_rate[EDGE_W-1:0] == $past(i_pwdata[EDGE_MSB:EDGE_LSB]))
		else $error("edge rate write lost");
endmodule
`default_nettype wire

/* uptt_fixture.sv */
`timescale 1ns/1ps
`default_nettype none
module uptt_fixture
	import uptt_pkg::*;
(
	input  wire logic [NPORT-1:0] i_plug,
	input  wire logic [NPORT-1:0] i_pad_power_down,
	output logic      [NPORT-1:0] o_attached
);
	// Fixture only seen once its pad is powered up
	assign o_attached = i_plug & ~i_pad_power_down;
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import uptt_pkg::*;
	logic                    clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic                    run_stop, halted;
	logic [31:0]             paddr, pwdata, prdata, pfuse, efuse, rd;
	logic [3:0]              pstrb;
	logic [NPORT-1:0]        plug, attached, power, tj, tk, tse0, tpkt, tfe, pad_down;
	logic [NPORT*EDGE_W-1:0] edge_rate;
	logic [NPORT*DRV_W-1:0]  drive;
	logic [NPORT*PULL_W-1:0] pull;
	logic [NPORT*TERM_W-1:0] term;
	logic [NPORT*EQ_W-1:0]   txeq, rxeq;
	logic [SQ_W-1:0]         squelch;
	logic [5:0]              drv;
	int                      mismatches, cmp_count;

	uptt_top uptt_top_i (.i_core_clk(clk), .i_resetn(rstn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_primary_fuse(pfuse), .i_extended_fuse(efuse), .i_port_attached(attached),
		.o_run_stop(run_stop), .o_controller_halted(halted), .o_port_power(power),
		.o_test_j(tj), .o_test_k(tk), .o_test_se0_nak(tse0), .o_test_packet(tpkt),
		.o_force_enable(tfe), .o_pad_power_down(pad_down), .o_edge_rate(edge_rate),
		.o_drive_strength(drive), .o_pulldown(pull), .o_termination(term),
		.o_txeq(txeq), .o_rxeq(rxeq), .o_squelch(squelch));
	uptt_fixture uptt_fixture_i (.i_plug(plug), .i_pad_power_down(pad_down),
		.o_attached(attached));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_of_test;
		if (mismatches == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge clk);
		end
		if (n == 16) begin
			mismatches++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask

	task automatic rd_exp(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic t_reset;
		rd_exp(PAD_CTL0_OFS[0], 32'h0400_0000);
		rd_exp(STS_OFS, 32'h0000_0001);
		chk(32'(halted), 32'h0000_0001);
		chk(32'(pad_down), 32'h0000_0007);
	endtask

	task automatic t_halt;
		int n;
		apb(1'b1, PORT_SC_OFS[1], 32'h0000_0200);
		chk(32'(power), 32'h0000_0002);
		apb(1'b1, PORT_SC_OFS[1], 32'h0000_0000);
		chk(32'(power), 32'h0000_0000);
		apb(1'b1, CMD_OFS, 32'h0000_0001);
		rd_exp(STS_OFS, 32'h0000_0000);
		apb(1'b1, CMD_OFS, 32'h0000_0000);
		chk(32'(run_stop), 32'h0000_0000);
		rd_exp(STS_OFS, 32'h0000_0000);
		n = 0;
		do begin
			apb(1'b0, STS_OFS, 32'h0);
			n++;
		end while (rd[0] !== 1'b1 && n < 12);
		chk(rd, 32'h0000_0001);
		chk(32'(halted), 32'h0000_0001);
	endtask

	task automatic t_modes;
		logic [31:0] exp;
		for (int c = 0; c < 7; c++) begin
			apb(1'b1, PORT_TC_OFS[1], {4'(c), 28'h0});
			exp = (c >= 1 && c <= 5) ? 32'h1 << (3 * (c - 1) + 1) : 32'h0;
			// Decoded outputs follow the stored field one edge later
			@(negedge clk);
			chk(32'({tfe, tpkt, tse0, tk, tj}), exp);
			rd_exp(PORT_TC_OFS[1], {4'(c), 28'h0});
		end
		apb(1'b1, PORT_TC_OFS[1], 32'h0);
	endtask

	task automatic t_pads;
		rd_exp(FUSE_PRI_OFS, pfuse & 32'h007F_FFBF);
		drv = pfuse[22:17] - 6'h04;
		apb(1'b0, PAD_CTL0_OFS[2], 32'h0);
		apb(1'b1, PAD_CTL0_OFS[2], (rd & ~32'h0400_01FF) | {23'h0, 3'h7, drv});
		chk(32'(drive[2*DRV_W +: DRV_W]), 32'(drv));
		chk(32'(drive[2*DRV_W-1:0]), 32'h0);
		chk(32'(edge_rate[2*EDGE_W +: EDGE_W]), 32'h7);
		chk(32'(pad_down), 32'h3);
		@(posedge clk);
		plug <= 3'b110;
		rd_exp(PORT_SC_OFS[2], 32'h1);
		rd_exp(PORT_SC_OFS[1], 32'h0);
		rd_exp(FUSE_EXT_OFS, efuse & 32'h0000_1FFF);
		apb(1'b1, PAD_CTL1_OFS[2], {1'b0, rd[4:0], 19'h0, rd[12:9], 3'h0});
		chk(32'(pull[2*PULL_W +: PULL_W]), 32'(efuse[4:0]));
		chk(32'(term[2*TERM_W +: TERM_W]), 32'(efuse[12:9]));
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, PAD_CTL3_OFS[0], {24'h0, 2'(c), 3'h0, 2'(3 - c), 1'b0});
			chk(32'({rxeq[1:0], txeq[1:0]}), 32'((c << 2) | (3 - c)));
		end
		apb(1'b1, BIAS_OFS, 32'h0000_0005);
		chk(32'(squelch), 32'h5);
		rd_exp(BIAS_OFS, 32'h0000_0005);
		apb(1'b1, FUSE_PRI_OFS, 32'h0);
		rd_exp(FUSE_PRI_OFS, pfuse & 32'h007F_FFBF);
		apb(1'b1, 32'h0352_0090, 32'hFFFF_FFFF);
		chk(32'(err), 32'h1);
		rd_exp(32'h0352_0090, 32'h0);
		chk(32'(err), 32'h1);
	endtask

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
		pfuse = 32'h1234_5678;
		efuse = 32'hABCD_E5B3;
		plug = 3'b000;
		mismatches = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_halt();
		t_modes();
		t_pads();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
